// ---- verilog/als_pkg.sv ----
`default_nettype none
package als_pkg;
   // ==========================================================
   // bus addressing and framing
   localparam logic [6:0] TARGET_ADDR = 7'h39;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam int SYNC_N = 3;
   localparam int COUNT_W = 16;
   localparam int EC_W = 3;
   localparam int MS_W = 9;
   // ==========================================================
   // command bytes
   localparam logic [7:0] CMD_CONV_START = 8'h00;
   localparam logic [7:0] CMD_CONV_DONE = 8'h03;
   localparam logic [7:0] CMD_EC0_CLR = 8'h1D;
   localparam logic [7:0] CMD_EC_DEFAULT = 8'h18;
   localparam logic [7:0] CMD_PREP_LOW = 8'h43;
   localparam logic [7:0] CMD_PREP_HIGH = 8'h83;
   localparam logic [7:0] CMD_EC1_SET = 8'h88;
   localparam logic [7:0] CMD_EC2_SET = 8'h90;
   // ==========================================================
   // integration time code
   localparam logic [EC_W-1:0] EC_DEFAULT = 3'h1;
   localparam logic [EC_W-1:0] EC_400MS = 3'h0;
   localparam logic [EC_W-1:0] EC_200MS = 3'h1;
   localparam logic [EC_W-1:0] EC_100MS = 3'h2;
   localparam int EC_BIT0 = 0;
   localparam int EC_BIT1 = 1;
   localparam int EC_BIT2 = 2;
   localparam logic [MS_W-1:0] EXP_MS_400 = 9'h190;
   localparam logic [MS_W-1:0] EXP_MS_200 = 9'h0C8;
   localparam logic [MS_W-1:0] EXP_MS_100 = 9'h064;
   localparam logic [MS_W-1:0] EXP_MS_NONE = 9'h000;
   // ==========================================================
   // controller bit timing
   localparam int SYS_HZ = 50_000_000;
   // fast rate; 100_000 selects the standard rate with the same logic
   localparam int SCL_HZ = 400_000;
   localparam int QUARTER_CYC = (SYS_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
   localparam int Q_W = 8;
   localparam logic [Q_W-1:0] QUARTER_LAST = Q_W'(QUARTER_CYC - 1);
endpackage : als_pkg
`default_nettype wire

// ---- verilog/als_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface als_link_if;
   logic scl_h_o;
   logic scl_h_oe;
   logic sda_h_o;
   logic sda_h_oe;
   logic sda_d_o;
   logic sda_d_oe;
   logic scl;
   logic sda;
   // ==========================================================
   // wired-and with pull-ups
   assign scl = !(scl_h_oe && !scl_h_o);
   assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));
   modport host (output scl_h_o, output scl_h_oe, output sda_h_o, output sda_h_oe,
                 input scl, input sda);
   modport device (output sda_d_o, output sda_d_oe, input scl, input sda);
endinterface : als_link_if
`default_nettype wire

// ---- verilog/als_target.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - answer and acknowledge only address 0x39
// - sixteen-bit count read as two bytes
// - result is sixteen-bit unsigned converter count
// - works at standard and fast bus rates
// - write: start, address msb first, bit low
// - read: start, address msb first, bit high
// - acknowledge matching address on ninth clock
// - one command byte msb first, then acknowledged
// - controller stops after acknowledged command byte
// - read shifts one data byte msb first
// - controller answers read byte with nack, stop
// - no repeated start; transactions stand alone
// - every transaction ends with a stop
// - settings change only through written commands
// - result passed to control logic for reads
// - code selects 400, 200, 100 ms exposure
// - start then complete conversion before byte prep
// - 0x43 low byte, 0x83 high byte next
// - 0x18 default, 0x1D, 0x88, 0x90 edit bits
module als_target (
   input wire logic clk_sys,
   input wire logic clk_link,
   input wire logic rst_n,
   als_link_if.device link,
   input wire logic [als_pkg::COUNT_W-1:0] adc_count,
   output logic [als_pkg::EC_W-1:0] integration_time_code,
   output logic [als_pkg::MS_W-1:0] exposure_ms,
   output logic conv_start,
   output logic conv_done,
   output logic [als_pkg::COUNT_W-1:0] light_count
);
   import als_pkg::*;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_WAIT_STOP
   } als_state_t;
   localparam int NSIG = 3;
   localparam logic [NSIG-1:0] LINK_RST = 3'h3;
   // ==========================================================
   // link side input filtering
   logic [NSIG-1:0] raw_in, filt_r, filt_q_r;
   logic rsp_tgl_r, cmd_tgl_r;
   logic [7:0] cmd_r, rd_byte_r, rd_hold_r;
   assign raw_in = {rsp_tgl_r, link.sda, link.scl};
   // agreement of second and third flop rejects glitches on slow edges
   genvar gi;
   generate
      for (gi = 0; gi < NSIG; gi++) begin : g_sync
         logic [SYNC_N-1:0] sh_r;
         always_ff @(posedge clk_link or negedge rst_n) begin
            if (!rst_n) begin
               sh_r <= {SYNC_N{LINK_RST[gi]}};
               filt_r[gi] <= LINK_RST[gi];
               filt_q_r[gi] <= LINK_RST[gi];
            end else begin
               sh_r <= {sh_r[SYNC_N-2:0], raw_in[gi]};
               if (sh_r[1] == sh_r[2]) begin
                  filt_r[gi] <= sh_r[2];
               end
               filt_q_r[gi] <= filt_r[gi];
            end
         end
      end
   endgenerate
   logic scl_f, sda_f, scl_rise, scl_fall, bus_start, bus_stop, rsp_ev;
   assign scl_f = filt_r[0];
   assign sda_f = filt_r[1];
   assign scl_rise = scl_f && !filt_q_r[0];
   assign scl_fall = !scl_f && filt_q_r[0];
   assign bus_start = scl_f && filt_q_r[0] && filt_q_r[1] && !sda_f;
   assign bus_stop = scl_f && filt_q_r[0] && !filt_q_r[1] && sda_f;
   assign rsp_ev = filt_r[2] ^ filt_q_r[2];
   // ==========================================================
   // bus state machine
   als_state_t state_r;
   logic [3:0] cnt_r;
   logic [7:0] rx_r, tx_r;
   logic rw_r, sda_oe_r, cmd_ev;
   // oversampled on the link clock; its latency fits the low phase at either rate
   always_ff @(posedge clk_link or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         cnt_r <= '0;
         rx_r <= '0;
         tx_r <= '0;
         rw_r <= 1'h0;
         sda_oe_r <= 1'h0;
      end else if (bus_stop) begin
         state_r <= ST_IDLE;
         cnt_r <= '0;
         sda_oe_r <= 1'h0;
      end else if (bus_start) begin
         // a start inside a transaction is not honoured: sit out until stop
         state_r <= (state_r == ST_IDLE) ? ST_ADDR : ST_WAIT_STOP;
         cnt_r <= '0;
         sda_oe_r <= 1'h0;
      end else begin
         case (state_r)
            ST_ADDR, ST_WR: begin
               if (scl_rise) begin
                  rx_r <= {rx_r[6:0], sda_f};
                  cnt_r <= cnt_r + 4'h1;
               end else if (scl_fall && cnt_r == BYTE_BITS) begin
                  if (state_r == ST_WR) begin
                     sda_oe_r <= 1'h1;
                     state_r <= ST_WR_ACK;
                  end else if (rx_r[7:1] == TARGET_ADDR) begin
                     rw_r <= rx_r[0];
                     sda_oe_r <= 1'h1;
                     state_r <= ST_ADDR_ACK;
                  end else begin
                     state_r <= ST_WAIT_STOP;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt_r <= '0;
                  if (rw_r) begin
                     tx_r <= rd_hold_r;
                     sda_oe_r <= !rd_hold_r[7];
                     state_r <= ST_RD;
                  end else begin
                     sda_oe_r <= 1'h0;
                     state_r <= ST_WR;
                  end
               end
            end
            ST_WR_ACK: begin
               if (scl_fall) begin
                  sda_oe_r <= 1'h0;
                  state_r <= ST_WAIT_STOP;
               end
            end
            ST_RD: begin
               if (scl_rise) begin
                  cnt_r <= cnt_r + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_r == BYTE_BITS) begin
                     sda_oe_r <= 1'h0;
                     state_r <= ST_RD_ACK;
                  end else begin
                     tx_r <= {tx_r[6:0], 1'h0};
                     sda_oe_r <= !tx_r[6];
                  end
               end
            end
            ST_RD_ACK: begin
               // only one byte per read whatever the controller answers
               if (scl_rise) begin
                  state_r <= ST_WAIT_STOP;
               end
            end
            ST_IDLE, ST_WAIT_STOP: state_r <= state_r;
            default: state_r <= ST_IDLE;
         endcase
      end
   end
   // scl_fall never meets a start or stop, which both need scl high
   assign cmd_ev = (state_r == ST_WR) && scl_fall && (cnt_r == BYTE_BITS);
   // ==========================================================
   // command hand-off to the system clock
   // cmd_r stays put between toggles, so the far side reads it safely
   always_ff @(posedge clk_link or negedge rst_n) begin
      if (!rst_n) begin
         cmd_r <= '0;
         cmd_tgl_r <= 1'h0;
      end else if (cmd_ev) begin
         cmd_r <= rx_r;
         cmd_tgl_r <= !cmd_tgl_r;
      end
   end
   always_ff @(posedge clk_link or negedge rst_n) begin
      if (!rst_n) begin
         rd_hold_r <= '0;
      end else if (rsp_ev) begin
         rd_hold_r <= rd_byte_r;
      end
   end
   assign link.sda_d_o = 1'h0;
   assign link.sda_d_oe = sda_oe_r;
   // ==========================================================
   // system side command execution
   logic [SYNC_N-1:0] cmd_sync_r;
   logic cmd_f_r, cmd_q_r, cmd_ev_sys;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cmd_sync_r <= '0;
         cmd_f_r <= 1'h0;
         cmd_q_r <= 1'h0;
      end else begin
         cmd_sync_r <= {cmd_sync_r[SYNC_N-2:0], cmd_tgl_r};
         if (cmd_sync_r[1] == cmd_sync_r[2]) begin
            cmd_f_r <= cmd_sync_r[2];
         end
         cmd_q_r <= cmd_f_r;
      end
   end
   assign cmd_ev_sys = cmd_f_r ^ cmd_q_r;
   logic [EC_W-1:0] ec_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ec_r <= EC_DEFAULT;
      end else if (cmd_ev_sys) begin
         case (cmd_r)
            CMD_EC_DEFAULT: ec_r <= EC_DEFAULT;
            CMD_EC0_CLR: ec_r[EC_BIT0] <= 1'h0;
            CMD_EC1_SET: ec_r[EC_BIT1] <= 1'h1;
            CMD_EC2_SET: ec_r[EC_BIT2] <= 1'h1;
            default: ec_r <= ec_r;
         endcase
      end
   end
   logic [MS_W-1:0] exposure_ms_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         exposure_ms_r <= EXP_MS_200;
      end else begin
         case (ec_r)
            EC_400MS: exposure_ms_r <= EXP_MS_400;
            EC_200MS: exposure_ms_r <= EXP_MS_200;
            EC_100MS: exposure_ms_r <= EXP_MS_100;
            default: exposure_ms_r <= EXP_MS_NONE;
         endcase
      end
   end
   // a complete without a prior start is ignored: no fresh count exists
   logic conv_busy_r, conv_start_r, conv_done_r;
   logic [COUNT_W-1:0] result_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         conv_busy_r <= 1'h0;
         conv_start_r <= 1'h0;
         conv_done_r <= 1'h0;
         result_r <= '0;
      end else begin
         conv_start_r <= cmd_ev_sys && cmd_r == CMD_CONV_START;
         conv_done_r <= cmd_ev_sys && cmd_r == CMD_CONV_DONE && conv_busy_r;
         if (cmd_ev_sys && cmd_r == CMD_CONV_START) begin
            conv_busy_r <= 1'h1;
         end else if (cmd_ev_sys && cmd_r == CMD_CONV_DONE && conv_busy_r) begin
            conv_busy_r <= 1'h0;
            result_r <= adc_count;
         end
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_byte_r <= '0;
         rsp_tgl_r <= 1'h0;
      end else if (cmd_ev_sys) begin
         rsp_tgl_r <= !rsp_tgl_r;
         if (cmd_r == CMD_PREP_LOW) begin
            rd_byte_r <= result_r[7:0];
         end else if (cmd_r == CMD_PREP_HIGH) begin
            rd_byte_r <= result_r[COUNT_W-1:8];
         end
      end
   end
   assign integration_time_code = ec_r;
   assign exposure_ms = exposure_ms_r;
   assign conv_start = conv_start_r;
   assign conv_done = conv_done_r;
   assign light_count = result_r;
endmodule : als_target
`default_nettype wire

// ---- verilog/als_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
module als_controller (
   input wire logic clk_sys,
   input wire logic rst_n,
   als_link_if.host link,
   input wire logic req,
   input wire logic req_read,
   input wire logic [7:0] req_byte,
   output logic busy,
   output logic done,
   output logic nack_err,
   output logic [7:0] rd_data
);
   import als_pkg::*;

   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} als_host_t;

   // ==========================================================
   // quarter-bit time base divided from the system clock
   logic [Q_W-1:0] qcnt_r;
   logic tick;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         qcnt_r <= '0;
      end else if (qcnt_r == QUARTER_LAST) begin
         qcnt_r <= '0;
      end else begin
         qcnt_r <= qcnt_r + 8'h01;
      end
   end
   assign tick = (qcnt_r == QUARTER_LAST);

   // ==========================================================
   // data line input
   logic [SYNC_N-1:0] sda_sync_r;
   logic sda_f_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sda_sync_r <= '1;
         sda_f_r <= 1'h1;
      end else begin
         sda_sync_r <= {sda_sync_r[SYNC_N-2:0], link.sda};
         if (sda_sync_r[1] == sda_sync_r[2]) begin
            sda_f_r <= sda_sync_r[2];
         end
      end
   end

   // ==========================================================
   // transaction sequencer
   als_host_t state_r;
   logic [1:0] phase_r;
   logic [3:0] bit_r;
   logic frame_r;
   logic rw_r;
   logic [7:0] byte_r;
   logic [7:0] tx_r;
   logic [7:0] rd_sh_r;
   logic ack_bad_r;
   logic scl_oe_r;
   logic sda_oe_r;
   logic done_r;
   logic nack_err_r;
   logic [7:0] rd_data_r;

   // no clock stretching is needed: the target never holds the clock
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= H_IDLE;
         phase_r <= '0;
         bit_r <= '0;
         frame_r <= 1'h0;
         rw_r <= 1'h0;
         byte_r <= '0;
         tx_r <= '0;
         rd_sh_r <= '0;
         ack_bad_r <= 1'h0;
         scl_oe_r <= 1'h0;
         sda_oe_r <= 1'h0;
         done_r <= 1'h0;
         nack_err_r <= 1'h0;
         rd_data_r <= '0;
      end else begin
         done_r <= 1'h0;
         if (state_r != H_IDLE && tick) begin
            phase_r <= phase_r + 2'h1;
         end
         case (state_r)
            H_IDLE: begin
               phase_r <= '0;
               if (req) begin
                  rw_r <= req_read;
                  byte_r <= req_byte;
                  tx_r <= {TARGET_ADDR, req_read};
                  nack_err_r <= 1'h0;
                  state_r <= H_START;
               end
            end
            H_START: begin
               if (tick && phase_r == 2'h1) begin
                  sda_oe_r <= 1'h1;
               end else if (tick && phase_r == 2'h3) begin
                  scl_oe_r <= 1'h1;
                  bit_r <= '0;
                  frame_r <= 1'h0;
                  ack_bad_r <= 1'h0;
                  state_r <= H_BIT;
               end
            end
            H_BIT: begin
               if (tick) begin
                  case (phase_r)
                     2'h0: sda_oe_r <= (bit_r == ACK_BIT) ? 1'h0 : !tx_r[7];
                     2'h1: scl_oe_r <= 1'h0;
                     2'h2: begin
                        if (bit_r == ACK_BIT) begin
                           if (!(frame_r && rw_r)) begin
                              ack_bad_r <= sda_f_r;
                           end
                        end else if (frame_r && rw_r) begin
                           rd_sh_r <= {rd_sh_r[6:0], sda_f_r};
                        end
                     end
                     default: begin
                        scl_oe_r <= 1'h1;
                        if (bit_r != ACK_BIT) begin
                           bit_r <= bit_r + 4'h1;
                           tx_r <= {tx_r[6:0], 1'h1};
                        end else if (!frame_r && !ack_bad_r) begin
                           bit_r <= '0;
                           frame_r <= 1'h1;
                           tx_r <= rw_r ? 8'hFF : byte_r;
                        end else begin
                           nack_err_r <= ack_bad_r && !(frame_r && rw_r);
                           state_r <= H_STOP;
                        end
                     end
                  endcase
               end
            end
            H_STOP: begin
               if (tick) begin
                  case (phase_r)
                     2'h0: sda_oe_r <= 1'h1;
                     2'h1: scl_oe_r <= 1'h0;
                     2'h2: sda_oe_r <= 1'h0;
                     default: begin
                        done_r <= 1'h1;
                        if (rw_r && !nack_err_r && frame_r) begin
                           rd_data_r <= rd_sh_r;
                        end
                        state_r <= H_IDLE;
                     end
                  endcase
               end
            end
            default: begin
               state_r <= H_IDLE;
            end
         endcase
      end
   end

   assign link.scl_h_o = 1'h0;
   assign link.scl_h_oe = scl_oe_r;
   assign link.sda_h_o = 1'h0;
   assign link.sda_h_oe = sda_oe_r;
   assign busy = (state_r != H_IDLE);
   assign done = done_r;
   assign nack_err = nack_err_r;
   assign rd_data = rd_data_r;
endmodule : als_controller
`default_nettype wire

// ---- sim/als_link_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module als_link_sva
   import als_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic scl_h_o,
   input wire logic scl_h_oe,
   input wire logic sda_h_o,
   input wire logic sda_h_oe,
   input wire logic sda_d_o,
   input wire logic sda_d_oe,
   input wire logic scl,
   input wire logic sda
);
   // ==========================================================
   // bus observer
   logic scl_last_r;
   logic sda_last_r;
   logic frame_r;
   logic rw_r;
   logic [4:0] rise_r;
   logic [6:0] addr_r;
   wire rise_w = scl && !scl_last_r;
   wire start_w = scl_last_r && scl && sda_last_r && !sda;
   wire stop_w = scl_last_r && scl && !sda_last_r && sda;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scl_last_r <= 1'b1;
         sda_last_r <= 1'b1;
      end else begin
         scl_last_r <= scl;
         sda_last_r <= sda;
      end
   end
   // saturates so a runaway frame cannot wrap back into a legal count
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rise_r <= 5'h00;
      end else if (start_w) begin
         rise_r <= 5'h00;
      end else if (rise_w && rise_r != 5'h1F) begin
         rise_r <= rise_r + 5'h01;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= 7'h00;
         rw_r <= 1'b0;
      end else if (rise_w && rise_r < 5'h07) begin
         addr_r <= {addr_r[5:0], sda};
      end else if (rise_w && rise_r == 5'h07) begin
         rw_r <= sda;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         frame_r <= 1'b0;
      end else if (start_w) begin
         frame_r <= 1'b1;
      end else if (stop_w) begin
         frame_r <= 1'b0;
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_start;
      scl_last_r && scl && sda_last_r && !sda;
   endsequence
   sequence s_stop;
      scl_last_r && scl && !sda_last_r && sda;
   endsequence
   property p_stop_release;
      s_stop |=> (!sda_d_oe) [*8];
   endproperty
   a_addr_match: assert property (rise_w && rise_r == 5'h07 |-> addr_r == TARGET_ADDR)
      else $error("address bits differ from target address");
   a_addr_ack: assert property (rise_w && rise_r == 5'h08 |-> !sda && sda_d_oe)
      else $error("no acknowledge on ninth clock");
   a_cmd_ack: assert property (rise_w && rise_r == 5'h11 && !rw_r |-> !sda && sda_d_oe)
      else $error("command byte not acknowledged");
   a_read_nack: assert property (rise_w && rise_r == 5'h11 && rw_r |-> sda && !sda_d_oe)
      else $error("read byte not ended by nack");
   a_read_release: assert property (rise_w && rw_r && rise_r inside {[5'h09:5'h10]}
      |-> !sda_h_oe)
      else $error("controller drives data during read byte");
   a_oe_stable_high: assert property (scl && scl_last_r |-> $stable(sda_d_oe))
      else $error("device data changes while clock high");
   a_stop_count: assert property (s_stop |-> rise_r == 5'h13)
      else $error("stop after wrong number of clocks");
   a_no_restart: assert property (s_start |-> !frame_r)
      else $error("start inside open frame");
   a_stop_release: assert property (p_stop_release)
      else $error("device holds data line after stop");
   a_sda_drain: assert property (sda_d_oe |-> !sda_d_o)
      else $error("device drives data line high");
   a_scl_drain: assert property (scl_h_oe |-> !scl_h_o)
      else $error("controller drives clock high");
endmodule : als_link_sva
`default_nettype wire

// ---- sim/tb_light_sensor_i2c_target_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_light_sensor_i2c_target_port;
   import als_pkg::*;
   logic clk_sys, clk_link, rst_n, req, req_read, busy, done, nack_err, conv_start, conv_done;
   logic [7:0] req_byte, rd_data;
   logic [15:0] adc_count, light_count;
   logic [2:0] integration_time_code;
   logic [8:0] exposure_ms;
   int err_count, comparisons, start_cnt, done_cnt;
   logic [7:0] ec_cmd [5] = '{8'h1D, 8'h88, 8'h90, 8'h55, 8'h18};
   logic [2:0] ec_exp [5] = '{3'h0, 3'h2, 3'h6, 3'h6, 3'h1};
   logic [8:0] ms_exp [5] = '{EXP_MS_400, EXP_MS_100, EXP_MS_NONE, EXP_MS_NONE, EXP_MS_200};
   als_link_if i_als_link_if();
   als_target i_als_target (.clk_sys(clk_sys), .clk_link(clk_link), .rst_n(rst_n),
      .link(i_als_link_if), .adc_count(adc_count),
      .integration_time_code(integration_time_code), .exposure_ms(exposure_ms),
      .conv_start(conv_start), .conv_done(conv_done), .light_count(light_count));
   als_controller i_als_controller (.clk_sys(clk_sys), .rst_n(rst_n), .link(i_als_link_if),
      .req(req), .req_read(req_read), .req_byte(req_byte), .busy(busy), .done(done),
      .nack_err(nack_err), .rd_data(rd_data));
   als_link_sva i_als_link_sva (.clk_sys(clk_sys), .rst_n(rst_n),
      .scl_h_o(i_als_link_if.scl_h_o), .scl_h_oe(i_als_link_if.scl_h_oe),
      .sda_h_o(i_als_link_if.sda_h_o), .sda_h_oe(i_als_link_if.sda_h_oe),
      .sda_d_o(i_als_link_if.sda_d_o), .sda_d_oe(i_als_link_if.sda_d_oe),
      .scl(i_als_link_if.scl), .sda(i_als_link_if.sda));
   // ==========================================================
   // clocks, pulse counters
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // odd offset keeps the link clock out of phase with the system clock
   initial begin
      clk_link = 1'b0;
      #7;
      forever #62.5 clk_link = ~clk_link;
   end
   always @(posedge clk_sys) begin
      if (conv_start === 1'b1) start_cnt++;
      if (conv_done === 1'b1) done_cnt++;
   end
   // ==========================================================
   // tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   // one whole transaction; waits for done under a bound
   task automatic xfer(input logic rd, input logic [7:0] b);
      int n;
      n = 0;
      @(posedge clk_sys);
      req <= 1'b1;
      req_read <= rd;
      req_byte <= b;
      @(posedge clk_sys);
      req <= 1'b0;
      #1 check(16'(busy), 16'h0001);
      while (done !== 1'b1 && n < 9000) begin
         @(posedge clk_sys) #1;
         n++;
      end
      check(16'(n < 9000), 16'h0001);
      check(16'(busy), 16'h0000);
      check(16'(nack_err), 16'h0000);
   endtask : xfer
   // ==========================================================
   // main sequence
   initial begin
      rst_n = 1'b0;
      req = 1'b0;
      req_read = 1'b0;
      req_byte = 8'h00;
      adc_count = 16'hA5C3;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      check(16'(integration_time_code), 16'(EC_DEFAULT));
      check(16'(exposure_ms), 16'(EXP_MS_200));
      check(light_count, 16'h0000);
      // let the link side settle before the first start
      repeat (8) @(posedge clk_sys);
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, ec_cmd[i]);
         check(16'(integration_time_code), 16'(ec_exp[i]));
         check(16'(exposure_ms), 16'(ms_exp[i]));
      end
      $display("test integration code done");
      xfer(1'b0, CMD_CONV_DONE);
      check(16'(done_cnt), 16'h0000);
      xfer(1'b0, CMD_CONV_START);
      check(16'(start_cnt), 16'h0001);
      xfer(1'b0, CMD_CONV_DONE);
      check(16'(done_cnt), 16'h0001);
      check(light_count, 16'hA5C3);
      // new converter value must not leak into the held result
      adc_count <= 16'h1234;
      xfer(1'b0, CMD_PREP_LOW);
      xfer(1'b1, 8'h00);
      check(16'(rd_data), 16'h00C3);
      xfer(1'b0, CMD_PREP_HIGH);
      xfer(1'b1, 8'h00);
      check(16'(rd_data), 16'h00A5);
      check(light_count, 16'hA5C3);
      check(16'(integration_time_code), 16'(EC_DEFAULT));
      $display("test conversion readout done");
      close_out();
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      err_count++;
      close_out();
   end
endmodule : tb_light_sensor_i2c_target_port
`default_nettype wire
